// ---- inc/reo_pkg.sv ----
package reo_pkg;
    localparam logic [7:0] OFS_DISABLE    = 8'h9f;
    localparam logic [7:0] OFS_FORCE_A    = 8'ha0;
    localparam logic [7:0] OFS_FORCE_B    = 8'ha1;
    // disable register fields
    localparam int BIT_SHARED_DIS = 7;
    localparam int BIT_SWITCH_B1_DISABLE   = 6;
    localparam int BIT_SWITCH_A1_DISABLE   = 5;
    localparam int BIT_TERM_DIS   = 4;
    // second override register fields
    localparam int BIT_TERM_EN    = 3;
    localparam int BIT_SHARED_EN  = 2;
    localparam int BIT_SWITCH_B1_FORCE_ON    = 1;
    localparam int BIT_LDO3_EN    = 0;
    localparam int LVL_LSB        = 4;
    // rail enable vector index
    localparam int NUM_RAILS      = 13;
    localparam int RAIL_STEP1     = 0;
    localparam int RAIL_LDO2      = 6;
    localparam int RAIL_LOAD_SWITCH_A1      = 7;
    localparam int RAIL_LDO3      = 8;
    localparam int RAIL_LOAD_SWITCH_B1      = 9;
    localparam int RAIL_SHARED    = 10;
    localparam int RAIL_TERM      = 11;
    localparam int RAIL_OTHER     = 12;
    localparam int NUM_GPO        = 4;
    // reset values
    localparam logic [7:0] RST_DISABLE = 8'hf0;
    localparam logic [7:0] RST_FORCE_A = 8'h00;
    localparam logic [7:0] RST_FORCE_B = 8'h00;
    localparam logic [7:0] RST_RDATA   = 8'h00;
endpackage

// ---- core/reo_rail_gate.sv ----
`timescale 1ns/10ps
module reo_rail_gate
    import reo_pkg::*;
(
    input  wire logic permit,     // disable bit, 1 allows the rail
    input  wire logic force_on,   // override bit
    input  wire logic pin_enable, // control pin or power-good enable
    output logic      rail_on     // effective enable
);
    assign rail_on = permit & (force_on | pin_enable);
endmodule // reo_rail_gate

// ---- core/reo_rail_enable_regs.sv ----
`timescale 1ns/10ps
// Contract
// - The disable register holds permit bits: bit 7 shared rail, 6 switch b1, 5 switch a1, 4 termination rail.
// - A permit bit of 0 keeps its rail off whatever the control pins do.
// - A factory setting chooses whether the shared bits act on load switch b2 or adjustable ldo one.
// - The first override register holds force bits for ldo two, switch a1 and step-down rails 6 to 1.
// - With its override bit 0 a rail follows its pin or power-good enable while its permit bit is 1.
// - With its override bit 1 a rail is forced on unless its permit bit is 0.
// - Second override bits 3, 2, 1 force the termination rail, shared rail and switch b1.
// - Second override bits 7 to 4 set the levels of general outputs 4 to 1 under register control.
// - A register-controlled output is driven low for level 0; for level 1 a push-pull output is driven high and an open-drain output is released.
// - Output 4 is open-drain only; outputs 1 to 3 may be open-drain or push-pull.
// - A non-register-controlled output follows its power-good tree and its level bit stays 0.
// - Second override bit 0 forces ldo three on unless its permit bit is 0.
module reo_rail_enable_regs
    import reo_pkg::*;
#(
    parameter logic [7:0] RESET_DISABLE = RST_DISABLE,
    parameter logic [7:0] RESET_FORCE_A = RST_FORCE_A,
    parameter logic [7:0] RESET_FORCE_B = RST_FORCE_B
)
(
    input  wire logic                 clk,            // 10 MHz clock
    input  wire logic                 reset,          // synchronous, active high
    input  wire logic [7:0]           reg_addr,       // register offset from serial front end
    input  wire logic [7:0]           reg_wdata,      // write byte
    input  wire logic                 reg_write,      // write strobe, one cycle
    input  wire logic                 reg_read,       // read strobe, one cycle
    output logic      [7:0]           reg_rdata,      // read byte, valid cycle after reg_read
    input  wire logic                 shared_sel_ldo, // factory: 1 shared bits act on ldo one, 0 on switch b2
    input  wire logic [NUM_GPO-1:0]   gpo_reg_ctl,    // factory: output is register controlled
    input  wire logic [NUM_GPO-1:0]   gpo_push_pull,  // factory: output is push-pull
    input  wire logic [NUM_GPO-1:0]   gpo_pg_tree,    // power-good tree level per output
    input  wire logic [NUM_RAILS-1:0] pin_enable,     // control pin or power-good enable per rail
    input  wire logic [NUM_RAILS-1:0] ext_permit,     // permit bits held in other banks
    output logic      [NUM_RAILS-1:0] rail_en,        // effective rail enables
    output logic                      switch_b2_en,   // load switch b2 enable
    output logic                      ldo_one_en,     // adjustable ldo one enable
    output logic      [NUM_GPO-1:0]   gpo_out,        // general output pin level
    output logic      [NUM_GPO-1:0]   gpo_oe          // general output pin drive enable
);
    typedef struct packed {
        logic [7:0]           dis;
        logic [7:0]           force_a;
        logic [7:0]           force_b;
        logic [7:0]           rdata;
        logic [NUM_RAILS-1:0] rail;
        logic                 load_switch_b2;
        logic                 ldo1;
        logic [NUM_GPO-1:0]   out;
        logic [NUM_GPO-1:0]   oe;
    } reo_state_type;

    reo_state_type        state_reg;
    reo_state_type        state_next;
    logic [NUM_RAILS-1:0] permit;
    logic [NUM_RAILS-1:0] force_on;
    logic [NUM_RAILS-1:0] gate_on;
    logic [NUM_GPO-1:0]   lvl_mask;
    logic [NUM_GPO-1:0]   ctl_eff;
    logic [NUM_GPO-1:0]   pp_eff;

    // output 4 cannot be push-pull
    assign pp_eff   = {1'b0, gpo_push_pull[NUM_GPO-2:0]};
    assign ctl_eff  = gpo_reg_ctl;
    assign lvl_mask = ctl_eff;

    always_comb
    begin
        permit                 = ext_permit;
        permit[RAIL_SHARED]    = state_reg.dis[BIT_SHARED_DIS];
        permit[RAIL_LOAD_SWITCH_B1]      = state_reg.dis[BIT_SWITCH_B1_DISABLE];
        permit[RAIL_LOAD_SWITCH_A1]      = state_reg.dis[BIT_SWITCH_A1_DISABLE];
        permit[RAIL_TERM]      = state_reg.dis[BIT_TERM_DIS];
        force_on               = '0;
        force_on[RAIL_STEP1+:6] = state_reg.force_a[5:0];
        force_on[RAIL_LDO2]    = state_reg.force_a[7];
        force_on[RAIL_LOAD_SWITCH_A1]    = state_reg.force_a[6];
        force_on[RAIL_TERM]    = state_reg.force_b[BIT_TERM_EN];
        force_on[RAIL_SHARED]  = state_reg.force_b[BIT_SHARED_EN];
        force_on[RAIL_LOAD_SWITCH_B1]    = state_reg.force_b[BIT_SWITCH_B1_FORCE_ON];
        force_on[RAIL_LDO3]    = state_reg.force_b[BIT_LDO3_EN];
    end

    genvar g;
    generate
        for (g = 0; g < NUM_RAILS; g = g + 1)
        begin : gen_gate
            reo_rail_gate u_gate
            (
                .permit     (permit[g]),
                .force_on   (force_on[g]),
                .pin_enable (pin_enable[g]),
                .rail_on    (gate_on[g])
            );
        end
    endgenerate

    always_comb
    begin
        state_next = state_reg;
        if (reg_write)
        begin
            case (reg_addr)
                OFS_DISABLE: state_next.dis     = reg_wdata;
                OFS_FORCE_A: state_next.force_a = reg_wdata;
                OFS_FORCE_B: state_next.force_b = {reg_wdata[7:LVL_LSB] & lvl_mask,
                                                   reg_wdata[LVL_LSB-1:0]};
                default:     state_next.dis     = state_reg.dis;
            endcase
        end
        // factory setting may change: unused level bits fall back to 0
        state_next.force_b[7:LVL_LSB] = state_next.force_b[7:LVL_LSB] & lvl_mask;
        if (reg_read)
        begin
            case (reg_addr)
                OFS_DISABLE: state_next.rdata = state_reg.dis;
                OFS_FORCE_A: state_next.rdata = state_reg.force_a;
                OFS_FORCE_B: state_next.rdata = state_reg.force_b;
                default:     state_next.rdata = RST_RDATA;
            endcase
        end
        state_next.rail = gate_on;
        // the shared pair: only the selected rail obeys the shared bits
        state_next.ldo1 = shared_sel_ldo ? gate_on[RAIL_SHARED] : (ext_permit[RAIL_SHARED]
                          & pin_enable[RAIL_SHARED]);
        state_next.load_switch_b2 = shared_sel_ldo ? (ext_permit[RAIL_SHARED] & pin_enable[RAIL_SHARED])
                          : gate_on[RAIL_SHARED];
        for (int i = 0; i < NUM_GPO; i++)
        begin
            if (ctl_eff[i])
            begin
                // level from register: push-pull drives both, open-drain only pulls low
                state_next.out[i] = pp_eff[i] & state_reg.force_b[LVL_LSB+i];
                state_next.oe[i]  = pp_eff[i] | ~state_reg.force_b[LVL_LSB+i];
            end
            else
            begin
                state_next.out[i] = pp_eff[i] & gpo_pg_tree[i];
                state_next.oe[i]  = pp_eff[i] | ~gpo_pg_tree[i];
            end
        end
        if (reset)
        begin
            state_next       = '0;
            state_next.dis   = RESET_DISABLE;
            state_next.force_a = RESET_FORCE_A;
            state_next.force_b = RESET_FORCE_B;
        end
    end

    always_ff @(posedge clk)
    begin
        state_reg <= state_next;
    end

    assign reg_rdata    = state_reg.rdata;
    assign rail_en      = state_reg.rail;
    assign switch_b2_en = state_reg.load_switch_b2;
    assign ldo_one_en   = state_reg.ldo1;
    assign gpo_out      = state_reg.out;
    assign gpo_oe       = state_reg.oe;

    sequence s_term_denied;
        !permit[RAIL_TERM];
    endsequence

    property p_dis_layout;
        @(posedge clk) disable iff (reset)
        reg_write && reg_addr == OFS_DISABLE |=> state_reg.dis == $past(reg_wdata);
    endproperty
    a_dis_layout: assert property (p_dis_layout) else $error("disable register not stored");

    property p_denied_off;
        @(posedge clk) disable iff (reset)
        s_term_denied |=> !rail_en[RAIL_TERM];
    endproperty
    a_denied_off: assert property (p_denied_off) else $error("denied rail is on");

    property p_shared_select;
        @(posedge clk) disable iff (reset)
        shared_sel_ldo && !permit[RAIL_SHARED] |=> !ldo_one_en;
    endproperty
    a_shared_select: assert property (p_shared_select) else $error("shared disable missed ldo one");

    property p_force_a;
        @(posedge clk) disable iff (reset)
        state_reg.force_a[2] && permit[2] |=> rail_en[2];
    endproperty
    a_force_a: assert property (p_force_a) else $error("step-down 3 not forced on");

    property p_force_ldo2;
        @(posedge clk) disable iff (reset)
        state_reg.force_a[7] && permit[RAIL_LDO2] |=> rail_en[RAIL_LDO2];
    endproperty
    a_force_ldo2: assert property (p_force_ldo2) else $error("ldo two not forced on");

    property p_follow_pin;
        @(posedge clk) disable iff (reset)
        !force_on[RAIL_LOAD_SWITCH_B1] && permit[RAIL_LOAD_SWITCH_B1] |=> rail_en[RAIL_LOAD_SWITCH_B1] == $past(pin_enable[RAIL_LOAD_SWITCH_B1]);
    endproperty
    a_follow_pin: assert property (p_follow_pin) else $error("rail not following pin");

    property p_force_b;
        @(posedge clk) disable iff (reset)
        state_reg.force_b[BIT_TERM_EN] && permit[RAIL_TERM] |=> rail_en[RAIL_TERM];
    endproperty
    a_force_b: assert property (p_force_b) else $error("termination rail not forced on");

    property p_ldo3;
        @(posedge clk) disable iff (reset)
        state_reg.force_b[BIT_LDO3_EN] && permit[RAIL_LDO3] |=> rail_en[RAIL_LDO3];
    endproperty
    a_ldo3: assert property (p_ldo3) else $error("ldo three not forced on");

    property p_gpo_level;
        @(posedge clk) disable iff (reset)
        ctl_eff[1] && pp_eff[1] ##1 ctl_eff[1] && pp_eff[1] |-> gpo_oe[1] && gpo_out[1] == $past(state_reg.force_b[5]);
    endproperty
    a_gpo_level: assert property (p_gpo_level) else $error("output 2 level wrong");

    property p_general_output_4_od;
        @(posedge clk) disable iff (reset)
        1'b1 |=> !gpo_out[3];
    endproperty
    a_general_output_4_od: assert property (p_general_output_4_od) else $error("output 4 driven high");

    property p_unused_lvl;
        @(posedge clk) disable iff (reset)
        !ctl_eff[0] |=> !state_reg.force_b[LVL_LSB];
    endproperty
    a_unused_lvl: assert property (p_unused_lvl) else $error("unused level bit set");

    property p_eval;
        @(posedge clk) disable iff (reset)
        1'b1 |=> rail_en == $past(permit & (force_on | pin_enable));
    endproperty
    a_eval: assert property (p_eval) else $error("rail enable equation wrong");
endmodule // reo_rail_enable_regs

// ---- testbench/reo_host_model.sv ----
`timescale 1ns/10ps
module reo_host_model
    import reo_pkg::*;
(
    input  wire logic       clk,       // bench clock
    output logic      [7:0] reg_addr,  // register offset
    output logic      [7:0] reg_wdata, // write byte
    output logic            reg_write, // write strobe
    output logic            reg_read   // read strobe
);
    initial
    begin
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
        reg_write = 1'b0;
        reg_read  = 1'b0;
    end
    // one byte per call, strobe up for a single edge
    task automatic write_byte(input logic [7:0] addr, input logic [7:0] data);
        @(posedge clk);
        reg_addr  <= addr;
        reg_wdata <= (addr == OFS_DISABLE) ? (data & 8'hf0) : data;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
        reg_wdata <= ~data;
    endtask
    task automatic read_byte(input logic [7:0] addr);
        @(posedge clk);
        reg_addr <= addr;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
    endtask
endmodule // reo_host_model

// ---- testbench/reo_rail_enable_regs_bench.sv ----
`timescale 1ns/10ps
module reo_rail_enable_regs_bench
    import reo_pkg::*;
;
    logic                 clk = 1'b0;
    logic                 reset = 1'b1;
    logic                 shared_sel_ldo = 1'b0;
    logic [NUM_GPO-1:0]   gpo_reg_ctl = '0, gpo_push_pull = '0, gpo_pg_tree = '0;
    logic [NUM_RAILS-1:0] pin_enable = '0, ext_permit = '0;
    logic [7:0]           reg_addr, reg_wdata, reg_rdata;
    logic                 reg_write, reg_read, switch_b2_en, ldo_one_en;
    logic [NUM_GPO-1:0]   gpo_out, gpo_oe;
    logic [NUM_RAILS-1:0] rail_en;
    logic [7:0]           exp_q[$];
    logic                 rd_seen = 1'b0;
    logic [7:0]           dis, fa, fb;
    logic [63:0]          rnd;
    int                   miscompares = 0;
    int                   compares = 0;
    int                   cycles = 0;
    integer               seed = 32'h56d2;

    reo_rail_enable_regs reo_rail_enable_regs_i (.clk(clk), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .shared_sel_ldo(shared_sel_ldo), .gpo_reg_ctl(gpo_reg_ctl), .gpo_push_pull(gpo_push_pull),
        .gpo_pg_tree(gpo_pg_tree), .pin_enable(pin_enable), .ext_permit(ext_permit), .rail_en(rail_en),
        .switch_b2_en(switch_b2_en), .ldo_one_en(ldo_one_en), .gpo_out(gpo_out), .gpo_oe(gpo_oe));
    reo_host_model reo_host_model_i (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read));

    initial
    begin
        forever #50 clk = ~clk;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        compares++;
        if (seen !== want)
        begin
            miscompares++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, want);
        end
    endtask

    task automatic end_sim;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            miscompares++;
            end_sim();
        end
    end

    // read answers land one cycle after the read edge
    always @(posedge clk)
        rd_seen <= reg_read;
    always @(negedge clk)
        if (rd_seen)
            check({8'h00, reg_rdata}, {8'h00, exp_q.pop_front()});

    task automatic rd(input logic [7:0] addr, input logic [7:0] want);
        exp_q.push_back(want);
        reo_host_model_i.read_byte(addr);
    endtask

    task automatic check_outputs;
        logic [NUM_RAILS-1:0] permit, force_v, want;
        logic [NUM_GPO-1:0]   lvl, pp;
        permit = ext_permit;
        permit[RAIL_LOAD_SWITCH_A1] = dis[BIT_SWITCH_A1_DISABLE];
        permit[RAIL_LOAD_SWITCH_B1] = dis[BIT_SWITCH_B1_DISABLE];
        permit[RAIL_SHARED] = dis[BIT_SHARED_DIS];
        permit[RAIL_TERM] = dis[BIT_TERM_DIS];
        force_v = '0;
        force_v[RAIL_STEP1 +: 6] = fa[5:0];
        force_v[RAIL_LOAD_SWITCH_A1] = fa[6];
        force_v[RAIL_LDO2] = fa[7];
        force_v[RAIL_LDO3] = fb[BIT_LDO3_EN];
        force_v[RAIL_LOAD_SWITCH_B1] = fb[BIT_SWITCH_B1_FORCE_ON];
        force_v[RAIL_SHARED] = fb[BIT_SHARED_EN];
        force_v[RAIL_TERM] = fb[BIT_TERM_EN];
        want = permit & (force_v | pin_enable);
        lvl = (gpo_reg_ctl & fb[7:4]) | (~gpo_reg_ctl & gpo_pg_tree);
        pp = gpo_push_pull & 4'h7;
        check({3'b000, rail_en}, {3'b000, want});
        check({15'h0000, shared_sel_ldo ? ldo_one_en : switch_b2_en}, {15'h0000, want[RAIL_SHARED]});
        check({15'h0000, shared_sel_ldo ? switch_b2_en : ldo_one_en},
              {15'h0000, ext_permit[RAIL_SHARED] & pin_enable[RAIL_SHARED]});
        check({8'h00, gpo_out, gpo_oe}, {8'h00, pp & lvl, pp | ~lvl});
    endtask

    initial
    begin
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        dis = RST_DISABLE;
        fa = RST_FORCE_A;
        fb = RST_FORCE_B;
        rd(OFS_DISABLE, RST_DISABLE);
        rd(OFS_FORCE_A, RST_FORCE_A);
        rd(OFS_FORCE_B, RST_FORCE_B);
        rd(8'h55, 8'h00);
        @(negedge clk);
        check_outputs();
        for (int n = 0; n < 40; n++)
        begin
            rnd = {$random(seed), $random(seed)};
            @(posedge clk);
            pin_enable <= rnd[12:0];
            ext_permit <= rnd[25:13];
            gpo_reg_ctl <= rnd[29:26];
            gpo_push_pull <= rnd[33:30];
            gpo_pg_tree <= rnd[37:34];
            shared_sel_ldo <= rnd[38];
            reo_host_model_i.write_byte(OFS_DISABLE, rnd[62:55]);
            reo_host_model_i.write_byte(OFS_FORCE_A, rnd[46:39]);
            reo_host_model_i.write_byte(OFS_FORCE_B, rnd[54:47]);
            reo_host_model_i.write_byte(8'h55, rnd[7:0]);
            dis = rnd[62:55] & 8'hf0;
            fa = rnd[46:39];
            fb = {rnd[54:51] & gpo_reg_ctl, rnd[50:47]};
            rd(OFS_DISABLE, dis);
            rd(OFS_FORCE_A, fa);
            rd(OFS_FORCE_B, fb);
            rd(8'h55, 8'h00);
            @(negedge clk);
            check_outputs();
        end
        repeat (2) @(posedge clk);
        end_sim();
    end
endmodule // reo_rail_enable_regs_bench
